// file: include/btc_cfg.svh
// bus trace capture constants
`ifndef BTC_CFG_SVH
`define BTC_CFG_SVH
`define BTC_DEPTH 4096
`define BTC_AW 12
`define BTC_CYC_PER_US 125
`define BTC_TIME_W 12
`define BTC_A_CTRL 8'h00
`define BTC_A_TPOS 8'h04
`define BTC_A_STAT 8'h08
`define BTC_A_RIDX 8'h0c
`define BTC_A_EPHY 8'h10
`define BTC_A_ELOG 8'h14
`define BTC_A_EDAT 8'h18
`define BTC_A_ETIM 8'h1c
`define BTC_A_SADR 8'h20
`define BTC_A_SDAT 8'h24
`define BTC_A_SCTL 8'h28
`define BTC_A_SCMD 8'h2c
`define BTC_A_DBNK 8'h30
`define BTC_A_DADR 8'h34
`define BTC_CF_IO 7
`define BTC_CF_RD 6
`define BTC_CF_DMA 5
`define BTC_F_DATA 42
`define BTC_F_CTRL 58
`define BTC_F_TIME 66
`endif

// file: include/btc_pkg.sv
// bus trace capture types
package btc_pkg;
	typedef enum logic [2:0] {
		BTC_IDLE, BTC_RUN, BTC_FILL, BTC_DONE, BTC_ABORT
	} btc_state_t;
endpackage

// file: rtl/btc_top.sv
// bus trace capture: snoop, trace memory, search, dump master, apb
`timescale 1ns/1ps
`include "btc_cfg.svh"
module btc_top #(
	parameter int DEPTH = `BTC_DEPTH,
	parameter int AW = `BTC_AW,
	parameter int CYC_PER_US = `BTC_CYC_PER_US
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic bus_cycle,
	input wire logic bus_trig,
	input wire logic bus_qual,
	input wire logic bus_local,
	input wire logic [7:0] bus_bank,
	input wire logic [15:0] bus_disp,
	input wire logic [1:0] bus_pit,
	input wire logic [15:0] bus_laddr,
	input wire logic [15:0] bus_data,
	input wire logic [7:0] bus_ctrl,
	output logic dma_req,
	output logic [23:0] dma_addr,
	input wire logic dma_ack,
	input wire logic [15:0] dma_rdata
);
	localparam int EW = `BTC_TIME_W + 8 + 16 + 16 + 2 + 8 + 16;
	localparam int IW = 1 + 1 + 1 + 1 + 8 + 16 + 2 + 16 + 16 + 8;
	localparam int DW = 1 + 16;

	btc_pkg::btc_state_t state_q;
	logic [IW-1:0] in1_q, in2_q;
	logic [DW-1:0] dm1_q, dm2_q;
	logic cyc_prev_q;
	logic [EW-1:0] mem [DEPTH];
	logic [AW-1:0] wp_q, trig_q, tpos_q, rem_q, cur_q, sidx_q, scnt_q;
	logic trig_seen_q;
	logic [7:0] us_pre_q;
	logic [`BTC_TIME_W-1:0] tim_q;
	logic [31:0] s_adr_q, s_dat_q;
	logic [15:0] s_ctl_q;
	logic s_busy_q, s_dir_q, s_found_q;
	logic [7:0] dbank_q;
	logic [15:0] ddata_q;
	logic dvalid_q, dbusy_q;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q, dma_req_q;
	logic [23:0] dma_addr_q;

	// unpacked view of the synchronised snoop inputs
	logic s_cyc, s_trg, s_qul, s_loc;
	logic [7:0] s_bank, s_ctrl;
	logic [15:0] s_disp, s_ladr, s_data;
	logic [1:0] s_pit;
	assign {s_cyc, s_trg, s_qul, s_loc, s_bank, s_disp, s_pit, s_ladr,
		s_data, s_ctrl} = in2_q;

	logic new_cyc, store, fire, wr_acc, rd_acc;
	logic [EW-1:0] entry, ent_rd, ent_s;
	logic [15:0] hit_dat;
	logic [7:0] hit_ctl;
	logic [15:0] ladr_eff;
	logic [7:0] ctrl_eff;
	logic [1:0] pit_eff;
	logic [AW-1:0] ref_idx, post_len;
	assign new_cyc = s_cyc & ~cyc_prev_q;
	// local cycles (cache, page tables, console, clock) are neither stored nor allowed to fire the trigger
	assign store = new_cyc & s_qul & ~s_loc &
		(state_q == btc_pkg::BTC_RUN || state_q == btc_pkg::BTC_FILL);
	assign fire = new_cyc & s_trg & ~s_loc & (state_q == btc_pkg::BTC_RUN);
	assign wr_acc = psel & penable & pwrite & ~pready_q;
	assign rd_acc = psel & penable & ~pwrite & ~pready_q;
	assign post_len = AW'(DEPTH - 1) - tpos_q;

	// dma entries carry only address, data and direction
	always_comb begin
		ladr_eff = s_ladr;
		ctrl_eff = {s_ctrl[7:1], 1'b0};
		pit_eff = s_pit;
		if (s_ctrl[`BTC_CF_IO]) begin
			ladr_eff = {6'h00, s_ladr[9:0]};
		end
		if (s_ctrl[`BTC_CF_DMA]) begin
			ladr_eff = 16'h0000;
			pit_eff = 2'h0;
			ctrl_eff = 8'h00;
			ctrl_eff[`BTC_CF_DMA] = 1'b1;
			ctrl_eff[`BTC_CF_RD] = s_ctrl[`BTC_CF_RD];
		end
	end
	// entry: time, ctrl, data, logical, page table, bank, displacement
	assign entry = {tim_q, ctrl_eff, s_data, ladr_eff, pit_eff,
		s_bank, s_disp};

	// without a trigger the newest entry acts as reference
	assign ref_idx = trig_seen_q ? trig_q : wp_q - AW'(1);
	assign ent_rd = mem[cur_q];
	assign ent_s = mem[sidx_q];
	assign hit_dat = ent_s[`BTC_F_DATA +: 16];
	assign hit_ctl = ent_s[`BTC_F_CTRL +: 8];

	// two-flop synchronisers for everything off the backplane
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in1_q <= '0;
			in2_q <= '0;
			dm1_q <= '0;
			dm2_q <= '0;
			cyc_prev_q <= 1'b0;
		end else if (ce) begin
			in1_q <= {bus_cycle, bus_trig, bus_qual, bus_local, bus_bank,
				bus_disp, bus_pit, bus_laddr, bus_data, bus_ctrl};
			in2_q <= in1_q;
			dm1_q <= {dma_ack, dma_rdata};
			dm2_q <= dm1_q;
			cyc_prev_q <= s_cyc;
		end
	end

	// trace memory is plain data, so it carries no reset
	always_ff @(posedge pclk) begin
		if (ce && store) begin
			mem[wp_q] <= entry;
		end
	end

	// capture sequence
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= btc_pkg::BTC_IDLE;
			wp_q <= '0;
			trig_q <= '0;
			rem_q <= '0;
			trig_seen_q <= 1'b0;
		end else if (ce) begin
			if (store) begin
				wp_q <= wp_q + AW'(1);
			end
			case (state_q)
			btc_pkg::BTC_IDLE, btc_pkg::BTC_DONE,
			btc_pkg::BTC_ABORT: begin
				if (wr_acc && paddr == `BTC_A_CTRL && pwdata[0]) begin
					state_q <= btc_pkg::BTC_RUN;
					wp_q <= '0;
					trig_seen_q <= 1'b0;
				end
			end
			btc_pkg::BTC_RUN: begin
				if (fire) begin
					// a trigger that fails qualification still counts
					trig_seen_q <= 1'b1;
					trig_q <= wp_q;
					if (tpos_q == AW'(DEPTH - 1) && store) begin
						state_q <= btc_pkg::BTC_DONE;
					end else begin
						// unstored trigger: its slot goes to the next entry
						rem_q <= store ? post_len : post_len + AW'(1);
						state_q <= btc_pkg::BTC_FILL;
					end
				end else if (wr_acc && paddr == `BTC_A_CTRL && pwdata[1]) begin
					state_q <= btc_pkg::BTC_ABORT;
				end
			end
			btc_pkg::BTC_FILL: begin
				if (store) begin
					rem_q <= rem_q - AW'(1);
					if (rem_q == AW'(1)) begin
						state_q <= btc_pkg::BTC_DONE;
					end
				end
			end
			default: state_q <= btc_pkg::BTC_IDLE;
			endcase
		end
	end

	// microsecond interval since the last stored entry, saturating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			us_pre_q <= '0;
			tim_q <= '0;
		end else if (ce) begin
			if (us_pre_q == 8'(CYC_PER_US - 1)) begin
				us_pre_q <= '0;
			end else begin
				us_pre_q <= us_pre_q + 8'h01;
			end
			if (store) begin
				tim_q <= '0;
			end else if (us_pre_q == 8'(CYC_PER_US - 1) && ~&tim_q) begin
				tim_q <= tim_q + `BTC_TIME_W'(1);
			end
		end
	end

	// entry search, one slot a cycle, at most DEPTH-1 slots (every slot but the cursor)
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_busy_q <= 1'b0;
			s_dir_q <= 1'b0;
			s_found_q <= 1'b0;
			sidx_q <= '0;
			scnt_q <= '0;
		end else if (ce) begin
			if (wr_acc && paddr == `BTC_A_SCMD && !s_busy_q &&
				|pwdata[2:0]) begin
				// repeat reuses the last direction
				if (!pwdata[2]) begin
					s_dir_q <= pwdata[1];
				end
				s_busy_q <= 1'b1;
				s_found_q <= 1'b0;
				scnt_q <= '0;
				if ((pwdata[2] && s_dir_q) || (!pwdata[2] && pwdata[1])) begin
					sidx_q <= cur_q - AW'(1);
				end else begin
					sidx_q <= cur_q + AW'(1);
				end
			end else if (s_busy_q) begin
				if (((ent_s[15:0] ^ s_adr_q[15:0]) & s_adr_q[31:16]) == 16'h0 &&
					((hit_dat ^ s_dat_q[15:0]) & s_dat_q[31:16]) == 16'h0 &&
					((hit_ctl ^ s_ctl_q[7:0]) & s_ctl_q[15:8]) == 8'h0) begin
					s_busy_q <= 1'b0;
					s_found_q <= 1'b1;
				end else if (scnt_q == AW'(DEPTH - 2)) begin
					s_busy_q <= 1'b0;
				end else begin
					scnt_q <= scnt_q + AW'(1);
					sidx_q <= s_dir_q ? sidx_q - AW'(1) : sidx_q + AW'(1);
				end
			end
		end
	end

	// read cursor: set relative to the reference, or follows the search index while a search runs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_q <= '0;
		end else if (ce) begin
			if (wr_acc && paddr == `BTC_A_RIDX) begin
				cur_q <= ref_idx + pwdata[AW-1:0];
			end else if (s_busy_q && !s_found_q) begin
				cur_q <= sidx_q;
			end
		end
	end

	// dump: one word per dma transfer, inside the selected bank
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dma_req_q <= 1'b0;
			dma_addr_q <= '0;
			dbusy_q <= 1'b0;
			dvalid_q <= 1'b0;
			ddata_q <= '0;
		end else if (ce) begin
			if (wr_acc && paddr == `BTC_A_DADR && !dbusy_q) begin
				dma_addr_q <= {dbank_q, pwdata[15:0]};
				dma_req_q <= 1'b1;
				dbusy_q <= 1'b1;
				dvalid_q <= 1'b0;
			end else if (dbusy_q && dma_req_q && dm2_q[16]) begin
				ddata_q <= dm2_q[15:0];
				dma_req_q <= 1'b0;
				dvalid_q <= 1'b1;
			end else if (dbusy_q && !dma_req_q && !dm2_q[16]) begin
				dbusy_q <= 1'b0; // ack has dropped, next word allowed
			end
		end
	end

	// software-written settings
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tpos_q <= '0;
			s_adr_q <= '0;
			s_dat_q <= '0;
			s_ctl_q <= '0;
			dbank_q <= '0;
		end else if (ce && wr_acc) begin
			if (paddr == `BTC_A_TPOS) begin
				tpos_q <= pwdata[AW-1:0];
			end else if (paddr == `BTC_A_SADR) begin
				s_adr_q <= pwdata;
			end else if (paddr == `BTC_A_SDAT) begin
				s_dat_q <= pwdata;
			end else if (paddr == `BTC_A_SCTL) begin
				s_ctl_q <= pwdata[15:0];
			end else if (paddr == `BTC_A_DBNK) begin
				dbank_q <= pwdata[7:0];
			end
		end
	end

	// apb answer, one wait state, unmapped gives pslverr
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= '0;
		end else if (ce) begin
			pready_q <= psel & penable & ~pready_q;
			pslverr_q <= 1'b0;
			prdata_q <= '0;
			if (rd_acc || wr_acc) begin
				if (paddr == `BTC_A_CTRL || paddr == `BTC_A_SCMD ||
					paddr == `BTC_A_DADR) begin
					prdata_q <= '0;
				end else if (paddr == `BTC_A_TPOS) begin
					prdata_q <= 32'(tpos_q);
				end else if (paddr == `BTC_A_STAT) begin
					prdata_q <= {24'h000000, dvalid_q, dbusy_q, s_found_q,
						s_busy_q, trig_seen_q, 3'(state_q)};
				end else if (paddr == `BTC_A_RIDX) begin
					prdata_q <= 32'(cur_q - ref_idx);
				end else if (paddr == `BTC_A_EPHY) begin
					prdata_q <= {8'h00, ent_rd[23:0]};
				end else if (paddr == `BTC_A_ELOG) begin
					prdata_q <= {14'h0000, ent_rd[25:24], ent_rd[41:26]};
				end else if (paddr == `BTC_A_EDAT) begin
					prdata_q <= {8'h00, ent_rd[`BTC_F_CTRL +: 8],
						ent_rd[`BTC_F_DATA +: 16]};
				end else if (paddr == `BTC_A_ETIM) begin
					prdata_q <= 32'(ent_rd[`BTC_F_TIME +: `BTC_TIME_W]);
				end else if (paddr == `BTC_A_SADR) begin
					prdata_q <= s_adr_q;
				end else if (paddr == `BTC_A_SDAT) begin
					prdata_q <= s_dat_q;
				end else if (paddr == `BTC_A_SCTL) begin
					prdata_q <= {16'h0000, s_ctl_q};
				end else if (paddr == `BTC_A_DBNK) begin
					prdata_q <= {8'h00, ddata_q, dbank_q};
				end else begin
					pslverr_q <= 1'b1;
				end
				if (wr_acc) begin
					prdata_q <= '0;
				end
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign dma_req = dma_req_q;
	assign dma_addr = dma_addr_q;
endmodule // btc_top

// file: tb/btc_host_dma.sv
// host memory answering the recorder's dump reads
`timescale 1ns/1ps
module btc_host_dma (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic dma_req,
	input wire logic [23:0] dma_addr,
	output logic dma_ack,
	output logic [15:0] dma_rdata
);
	logic [3:0] wait_q;
	// one word per request; data toggles when not acked so stale
	// values never look valid
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dma_ack <= 1'b0;
			dma_rdata <= 16'h0;
			wait_q <= 4'h0;
		end else if (dma_req && !dma_ack) begin
			wait_q <= wait_q + 4'h1;
			if (wait_q == (slow ? 4'h9 : 4'h1)) begin
				dma_ack <= 1'b1;
				dma_rdata <= dma_addr[15:0] ^ {dma_addr[23:16], 8'h5a};
			end else begin
				dma_rdata <= ~dma_rdata;
			end
		end else if (!dma_req) begin
			dma_ack <= 1'b0; // ack held until request drops
			wait_q <= 4'h0;
			dma_rdata <= ~dma_rdata;
		end
	end
endmodule // btc_host_dma

// file: tb/btc_props.sv
// checker for the trace recorder apb and dma ports
`timescale 1ns/1ps
module btc_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic dma_req,
	input wire logic [23:0] dma_addr,
	input wire logic dma_ack
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// apb answer timing and shape
	ack_wait_a: assert property (ce && psel && penable && !pready |=> pready)
		else $error("apb access not answered after one wait");
	ack_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data not zero outside answer");
	err_map_a: assert property (pready |->
		pslverr == (paddr > 8'h34 || paddr[1:0] != 2'h0))
		else $error("error flag disagrees with address map");
	// dump master only after a start write, holds address until acked
	dma_start_a: assert property ($rose(dma_req) |-> pready &&
		paddr == 8'h34) else $error("dump read without start");
	dma_addr_a: assert property (dma_req && $past(dma_req) |->
		$stable(dma_addr)) else $error("dump address moved");
	dma_end_a: assert property ($rose(dma_ack) |-> ##[1:5] !dma_req)
		else $error("dump request not dropped after ack");
	dma_drop_a: assert property ($fell(dma_req) |-> $past(dma_ack) &&
		$past(dma_ack, 2)) else $error("dump request dropped unacked");
endmodule // btc_props

// file: tb/test_bus_trace_capture.sv
// testbench for the bus trace capture block
`timescale 1ns/1ps
module test_bus_trace_capture;
	typedef struct packed {
		logic w;
		logic [7:0] a;
		logic [31:0] d;
		logic [31:0] e;
		logic x;
	} btc_row_t;
	logic pclk, presetn, psel, penable, pwrite, slow, pready, pslverr, er;
	logic dma_req, dma_ack, bus_cycle, bus_trig, bus_qual, bus_local;
	logic [7:0] paddr, bus_bank, bus_ctrl;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] bus_disp, bus_laddr, bus_data, dma_rdata;
	logic [1:0] bus_pit;
	logic [23:0] dma_addr;
	int errors, n_compared;
	btc_row_t rows[7];
	// small memory keeps fill reachable: 15-tpos entries after trigger
	btc_top #(.DEPTH(16), .AW(4), .CYC_PER_US(125)) dut_u (
		.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bus_cycle(bus_cycle), .bus_trig(bus_trig),
		.bus_qual(bus_qual), .bus_local(bus_local), .bus_bank(bus_bank),
		.bus_disp(bus_disp), .bus_pit(bus_pit), .bus_laddr(bus_laddr),
		.bus_data(bus_data), .bus_ctrl(bus_ctrl), .dma_req(dma_req),
		.dma_addr(dma_addr), .dma_ack(dma_ack), .dma_rdata(dma_rdata));
	btc_host_dma host_u (.clk(pclk), .rst_n(presetn), .slow(slow),
		.dma_req(dma_req), .dma_addr(dma_addr), .dma_ack(dma_ack),
		.dma_rdata(dma_rdata));
	// clock
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	task chk(input logic [31:0] g, input logic [31:0] x);
		n_compared++;
		if (g !== x) begin
			errors++;
			$display("BAD %0t got %h want %h", $time, g, x);
		end
	endtask
	// apb transfer, waits for pready under a bound
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k == 20) chk(32'h0, 32'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// one backplane cycle; fields settle before the strobe and stay
	task cyc(input logic t, q, l, input logic [7:0] i, c);
		@(posedge pclk);
		bus_trig <= t;
		bus_qual <= q;
		bus_local <= l;
		bus_bank <= i;
		bus_disp <= {8'h10, i};
		bus_laddr <= {8'hfe, i};
		bus_data <= {8'h30, i};
		bus_ctrl <= c;
		repeat (2) @(posedge pclk);
		bus_cycle <= 1'b1;
		repeat (5) @(posedge pclk);
		bus_cycle <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask
	task dump(input logic [15:0] p, input logic [7:0] b);
		apb(1'b1, 8'h30, {24'h0, b});
		apb(1'b1, 8'h34, {16'h0, p});
		repeat (40) begin
			apb(1'b0, 8'h08, 32'h0);
			if (rd[6] == 1'b0) break;
		end
		chk(rd & 32'hc0, 32'h80);
		apb(1'b0, 8'h30, 32'h0);
		chk(rd, {8'h0, p ^ {b, 8'h5a}, b});
	endtask
	task stat(input logic [31:0] x);
		apb(1'b0, 8'h08, 32'h0);
		chk(rd & 32'hf, x);
	endtask
	// search command, then found flag and cursor relative to trigger
	task srch(input logic [31:0] c, input logic [31:0] x);
		apb(1'b1, 8'h2c, c);
		repeat (20) @(posedge pclk);
		apb(1'b0, 8'h08, 32'h0);
		chk(rd & 32'h30, 32'h20);
		apb(1'b0, 8'h0c, 32'h0);
		chk(rd, x);
	endtask
	task end_of_test;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// watchdog
	initial begin
		repeat (20000) @(posedge pclk);
		chk(32'h0, 32'h1);
		end_of_test;
	end
	initial begin
		{presetn, psel, penable, pwrite, slow, paddr, pwdata} = '0;
		{bus_cycle, bus_trig, bus_qual, bus_local, bus_bank} = '0;
		{bus_ctrl, bus_disp, bus_laddr, bus_data, bus_pit} = '0;
		bus_pit = 2'h1;
		rows = '{'{1, 8'h04, 9, 0, 0}, '{0, 8'h04, 0, 9, 0},
			'{0, 8'h00, 0, 0, 0}, '{0, 8'h08, 0, 0, 0},
			'{1, 8'h30, 5, 0, 0}, '{0, 8'h30, 0, 5, 0},
			'{0, 8'h3c, 0, 0, 1}};
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[j]) begin
			apb(rows[j].w, rows[j].a, rows[j].d);
			if (!rows[j].w) chk(rd, rows[j].e);
			chk({31'h0, er}, {31'h0, rows[j].x});
		end
		$display("register table done");
		// capture: skipped cycles, io trigger, dma entry, fill
		apb(1'b1, 8'h04, 32'ha);
		apb(1'b1, 8'h00, 32'h1);
		stat(32'h1);
		cyc(0, 1, 0, 8'h01, 8'h52);
		cyc(0, 1, 0, 8'h03, 8'h52);
		cyc(0, 0, 0, 8'h02, 8'h52);
		cyc(0, 1, 1, 8'h04, 8'h52);
		cyc(1, 1, 0, 8'h80, 8'hc6);
		stat(32'ha);
		for (int i = 1; i < 5; i++) cyc(0, 1, 0, 8'h80 + i[7:0], 8'h7e);
		stat(32'ha);
		// a long gap gives this entry a time of two or three us
		repeat (260) @(posedge pclk);
		cyc(0, 1, 0, 8'h85, 8'h52);
		stat(32'hb);
		cyc(0, 1, 0, 8'h86, 8'h52);
		apb(1'b1, 8'h0c, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h00801080);
		apb(1'b0, 8'h14, 32'h0);
		chk(rd, 32'h00010280);
		apb(1'b0, 8'h18, 32'h0);
		chk(rd, 32'h00c63080);
		apb(1'b1, 8'h0c, 32'h1);
		apb(1'b0, 8'h14, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h18, 32'h0);
		chk(rd, 32'h00603081);
		apb(1'b1, 8'h0c, 32'hfff);
		apb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h00031003);
		apb(1'b1, 8'h0c, 32'h5);
		apb(1'b0, 8'h1c, 32'h0);
		chk({31'h0, rd inside {32'h2, 32'h3}}, 32'h1);
		$display("capture done");
		// search: backward on dma flag, repeat, forward on address
		apb(1'b1, 8'h28, 32'h2020);
		srch(32'h2, 32'h4);
		srch(32'h4, 32'h3);
		apb(1'b1, 8'h28, 32'h0);
		apb(1'b1, 8'h20, 32'hffff1085);
		srch(32'h1, 32'h5);
		$display("search done");
		// abort before trigger, then trigger at last slot
		apb(1'b1, 8'h00, 32'h1);
		cyc(0, 1, 0, 8'h41, 8'h52);
		apb(1'b1, 8'h00, 32'h2);
		stat(32'h4);
		apb(1'b1, 8'h0c, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h00411041);
		apb(1'b1, 8'h04, 32'hf);
		apb(1'b1, 8'h00, 32'h1);
		cyc(1, 1, 0, 8'h90, 8'h52);
		stat(32'hb);
		// unqualified trigger: its slot goes to the next entry
		apb(1'b1, 8'h00, 32'h1);
		cyc(1, 0, 0, 8'h91, 8'h52);
		stat(32'ha);
		cyc(0, 1, 0, 8'h92, 8'h52);
		stat(32'hb);
		apb(1'b1, 8'h0c, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h00921092);
		$display("abort and end trigger done");
		// dumps, prompt host then slow host
		dump(16'h3456, 8'h12);
		slow <= 1'b1;
		dump(16'h0001, 8'h07);
		$display("dump done");
		// reset with the capture done
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		chk({29'h0, pready, pslverr, dma_req}, 32'h0);
		chk(prdata, 32'h0);
		presetn <= 1'b1;
		apb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h0);
		stat(32'h0);
		$display("reset done");
		end_of_test;
	end
endmodule // test_bus_trace_capture
bind btc_top btc_props chk_u (.pclk(pclk), .presetn(presetn), .ce(ce),
	.psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .dma_req(dma_req),
	.dma_addr(dma_addr), .dma_ack(dma_ack));
